// ===== hdl/pnp_port.sv
// parallel high-voltage programming port: command, address and data latches, page buffer,
// fuse/lock bytes, eeprom array and busy timer
// assumes programmer pins synchronous to core_clk_i; flash array is outside (word in, address/write/erase out ports)
`timescale 1ns/10ps
`include "pnp_regs.svh"
module pnp_port #(
  parameter int unsigned WRITE_CYC = `PNP_WRITE_CYC,
  parameter int unsigned ERASE_CYC = `PNP_ERASE_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  input  wire logic        load_sel_hi_i,
  input  wire logic        load_sel_lo_i,
  input  wire logic        byte_sel_a_i,
  input  wire logic        byte_sel_b_i,
  input  wire logic        buffer_latch_i,
  input  wire logic        load_strobe_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_n_i,
  output logic             done_flag_o,
  input  wire logic [15:0] flash_word_i,
  output logic [15:0]      flash_addr_o,
  output logic             flash_write_o,
  output logic             flash_erase_o,
  output logic [7:0]       fuse_lo_o,
  output logic [7:0]       fuse_hi_o,
  output logic [7:0]       fuse_ex_o,
  output logic [7:0]       lock_o
);
  localparam int unsigned EE_BYTES = 512;
  localparam logic [7:0] SIG0 = 8'h3A; // arbitrary value
  localparam logic [7:0] SIG1 = 8'h55; // arbitrary value
  localparam logic [7:0] SIG2 = 8'hAA; // arbitrary value

  typedef struct packed {
    pnp_pkg::pnp_state_e state;
    logic [7:0]          cmd;
    logic [7:0]          addr_hi;
    logic [7:0]          addr_lo;
    logic [7:0]          data_lo;
    logic [7:0]          data_hi;
    logic [31:0]         page;
    logic [3:0]          page_vld;
    logic [8:2]          page_idx;
    pnp_pkg::pnp_nv_s    nv;
    logic [23:0]         timer;
    logic                wr_ee;
    logic                wr_flash;
    logic                erase;
    logic [7:0]          dout;
  } pnp_st_s;

  pnp_st_s    st_reg;
  pnp_st_s    st_next;
  logic [7:0] ee_mem [EE_BYTES];
  logic       ld_rise;
  logic       pl_rise;
  logic       wr_fall;
  logic       ee_commit;
  logic       ee_clear;

  // write strobe edge on inverted wr_n_i; rst_val_i high only arms the unused falling edge output
  pnp_edge u_wr (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .sig_i      (~wr_n_i),
    .rst_val_i  (1'b1),
    .rise_o     (wr_fall),
    .fall_o     ()
  );
  pnp_edge u_ld (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .sig_i      (load_strobe_i),
    .rst_val_i  (1'b1),
    .rise_o     (ld_rise),
    .fall_o     ()
  );
  pnp_edge u_pl (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .sig_i      (buffer_latch_i),
    .rst_val_i  (1'b1),
    .rise_o     (pl_rise),
    .fall_o     ()
  );

  // lock bits only move toward programmed
  function automatic logic [7:0] lock_merge(input logic [7:0] cur, input logic [7:0] req);
    logic [7:0] res;
    res = cur & req;
    if (cur[1:0] == 2'b00) begin
      res[7:2] = cur[7:2];
    end
    return res;
  endfunction : lock_merge

  // next state
  always_comb begin
    st_next   = st_reg;
    ee_commit = 1'b0;
    ee_clear  = 1'b0;
    // loads on the load strobe
    if (ld_rise) begin
      unique case ({load_sel_hi_i, load_sel_lo_i})
        `PNP_LD_ADDR: begin
          if (byte_sel_a_i) begin
            st_next.addr_hi = data_i;
          end else begin
            st_next.addr_lo = data_i;
          end
        end
        `PNP_LD_DATA: begin
          if (byte_sel_a_i) begin
            st_next.data_hi = data_i;
          end else begin
            st_next.data_lo = data_i;
          end
        end
        `PNP_LD_CMD: begin
          st_next.cmd = data_i;
          if (data_i == `PNP_CMD_NOP) begin
            st_next.page_vld = 4'h0;
            st_next.wr_ee    = 1'b0;
            st_next.wr_flash = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // fsm: write strobes only taken when idle
    unique case (st_reg.state)
      pnp_pkg::PNP_IDLE: begin
        if (wr_fall) begin
          st_next.timer = 24'(WRITE_CYC);
          st_next.state = pnp_pkg::PNP_BUSY;
          unique case (st_reg.cmd)
            `PNP_CMD_WEE: begin
              if (!byte_sel_a_i) begin
                st_next.wr_ee = 1'b1;
              end else begin
                st_next.state = pnp_pkg::PNP_IDLE;
              end
            end
            `PNP_CMD_WFLASH: st_next.wr_flash = 1'b1;
            `PNP_CMD_WFUSE: begin
              unique case ({byte_sel_b_i, byte_sel_a_i})
                2'b01:   st_next.nv.fuse_hi = st_reg.data_lo;
                2'b10:   st_next.nv.fuse_ex = st_reg.data_lo;
                default: st_next.nv.fuse_lo = st_reg.data_lo;
              endcase
            end
            `PNP_CMD_WLOCK: st_next.nv.lock = lock_merge(st_reg.nv.lock, st_reg.data_lo);
            `PNP_CMD_ERASE: begin
              st_next.timer = 24'(ERASE_CYC);
              st_next.state = pnp_pkg::PNP_ERASE;
              st_next.erase = 1'b1;
            end
            default: st_next.timer = 24'h000001;
          endcase
        end
      end
      pnp_pkg::PNP_BUSY: begin
        st_next.timer = st_reg.timer - 24'h000001;
        if (st_reg.timer == 24'h000001) begin
          st_next.state    = pnp_pkg::PNP_IDLE;
          ee_commit        = st_reg.wr_ee;
          st_next.wr_ee    = 1'b0;
          st_next.wr_flash = 1'b0;
          if (st_reg.wr_ee) begin
            st_next.page_vld = 4'h0;
          end
        end
      end
      pnp_pkg::PNP_ERASE: begin
        st_next.timer = st_reg.timer - 24'h000001;
        if (st_reg.timer == 24'h000001) begin
          st_next.state   = pnp_pkg::PNP_IDLE;
          st_next.erase   = 1'b0;
          st_next.nv.lock = `PNP_LOCK_RST;
          ee_clear        = st_reg.nv.fuse_hi[3];
        end
      end
      default: st_next.state = pnp_pkg::PNP_IDLE;
    endcase
    // page latch fills one eeprom byte; after the fsm so a latch beats the page clear
    if (pl_rise && st_reg.cmd == `PNP_CMD_WEE) begin
      st_next.page[st_reg.addr_lo[1:0]*8 +: 8]  = st_reg.data_lo;
      st_next.page_vld[st_reg.addr_lo[1:0]]     = 1'b1;
      st_next.page_idx = {st_reg.addr_hi[0], st_reg.addr_lo[7:2]};
    end
    // read mux, registered
    unique case (st_reg.cmd)
      `PNP_CMD_RFLASH: st_next.dout = byte_sel_a_i ? flash_word_i[15:8] : flash_word_i[7:0];
      `PNP_CMD_REE:    st_next.dout = ee_mem[{st_reg.addr_hi[0], st_reg.addr_lo}];
      `PNP_CMD_RFUSE: begin
        unique case ({byte_sel_b_i, byte_sel_a_i})
          2'b00:   st_next.dout = st_reg.nv.fuse_lo;
          2'b11:   st_next.dout = st_reg.nv.fuse_hi;
          2'b10:   st_next.dout = st_reg.nv.fuse_ex;
          default: st_next.dout = st_reg.nv.lock;
        endcase
      end
      `PNP_CMD_RSIG: begin
        if (byte_sel_a_i) begin
          st_next.dout = (st_reg.addr_lo == 8'h00) ? `PNP_CAL_VAL : 8'hFF;
        end else if (st_reg.addr_lo == 8'h00) begin
          st_next.dout = SIG0;
        end else if (st_reg.addr_lo == 8'h01) begin
          st_next.dout = SIG1;
        end else begin
          st_next.dout = (st_reg.addr_lo == 8'h02) ? SIG2 : 8'hFF;
        end
      end
      default: st_next.dout = 8'hFF;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg            <= '0;
      st_reg.state      <= pnp_pkg::PNP_IDLE;
      st_reg.nv.fuse_lo <= `PNP_FUSE_LO_RST;
      st_reg.nv.fuse_hi <= `PNP_FUSE_HI_RST;
      st_reg.nv.fuse_ex <= `PNP_FUSE_EX_RST;
      st_reg.nv.lock    <= `PNP_LOCK_RST;
      st_reg.dout       <= 8'hFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // eeprom array, page commit and erase
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < EE_BYTES; i++) begin
      if (ee_clear) begin
        ee_mem[i] <= 8'hFF;
      end else if (ee_commit && st_reg.page_vld[i % 4] && (i / 4) == int'(st_reg.page_idx)) begin
        ee_mem[i] <= st_reg.page[(i % 4)*8 +: 8];
      end
    end
  end

  // outputs
  assign data_o        = st_reg.dout;
  assign data_oe_o     = ~oe_n_i;
  assign done_flag_o   = (st_reg.state == pnp_pkg::PNP_IDLE);
  assign flash_addr_o  = {st_reg.addr_hi, st_reg.addr_lo};
  assign flash_write_o = st_reg.wr_flash;
  assign flash_erase_o = st_reg.erase;
  assign fuse_lo_o     = st_reg.nv.fuse_lo;
  assign fuse_hi_o     = st_reg.nv.fuse_hi;
  assign fuse_ex_o     = st_reg.nv.fuse_ex;
  assign lock_o        = st_reg.nv.lock;

  // busy within the allowed delay after a write strobe taken while idle, eeprom write command excluded
  property p_busy_fast;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (wr_fall && done_flag_o && st_reg.cmd != `PNP_CMD_WEE) |=> !done_flag_o;
  endproperty
  a_busy_fast: assert property (p_busy_fast) else $error("busy not raised");

  // fuse write busy lasts at least two cycles after the strobe
  sequence s_wr_start;
    wr_fall && done_flag_o && st_reg.cmd == `PNP_CMD_WFUSE;
  endsequence
  property p_write_len;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_wr_start |=> !done_flag_o [*2];
  endproperty
  a_write_len: assert property (p_write_len) else $error("write busy too short");

  // erase clears lock bits on completion
  property p_erase_lock;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (st_reg.state == pnp_pkg::PNP_ERASE && st_reg.timer == 24'h000001) |=> lock_o == 8'hFF;
  endproperty
  a_erase_lock: assert property (p_erase_lock) else $error("erase left locks");

  // lock bits never go from programmed back to erased outside erase
  property p_lock_mono;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (st_reg.state != pnp_pkg::PNP_ERASE) |=> ((lock_o & ~$past(lock_o)) == 8'h00);
  endproperty
  a_lock_mono: assert property (p_lock_mono) else $error("lock bit erased");

  // boot locks frozen in lock mode 3
  property p_boot_frozen;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (lock_o[1:0] == 2'b00 && st_reg.state == pnp_pkg::PNP_IDLE) |=> lock_o[7:2] == $past(lock_o[7:2]);
  endproperty
  a_boot_frozen: assert property (p_boot_frozen) else $error("boot lock changed");

  // strobes ignored while busy
  property p_ignore_busy;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (!done_flag_o && wr_fall) |=> st_reg.nv == $past(st_reg.nv) || st_reg.state == pnp_pkg::PNP_IDLE;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("write taken while busy");

  // nop command clears internal write state
  property p_nop;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ld_rise && {load_sel_hi_i, load_sel_lo_i} == `PNP_LD_CMD && data_i == 8'h00) |=> st_reg.page_vld == 4'h0;
  endproperty
  a_nop: assert property (p_nop) else $error("nop left page state");

  // bus driven exactly while output enable low
  property p_drive;
    @(posedge core_clk_i) disable iff (!rstn_i)
      data_oe_o == !oe_n_i;
  endproperty
  a_drive: assert property (p_drive) else $error("bus drive mismatch");
endmodule : pnp_port

// ===== hdl/pnp_regs.svh
// constants of the parallel programming port: command codes, select codes, timing counts
// assumes a 200 MHz core clock; included by bare name
// Functional notes
// - loading command 0x00 ends a page session and clears internal write state.
// - write strobe low with byte select a at 0 starts the eeprom page write.
// - flash read shows word low byte for select a 0, high byte for 1.
// - eeprom read shows the addressed byte while output enable low, select a 0.
// - fuse low write: each 0 bit programs, each 1 bit erases the fuse.
// - lock write: a 0 data bit programs the matching lock bit.
// - with both general lock bits programmed, boot lock bits cannot be programmed.
// - lock bits return to erased only through chip erase.
// - fuse/lock read selects by (b,a): 00 low, 11 high, 10 extended, 01 lock.
// - signature command with address 0..2 shows the signature byte, select a 0.
// - signature command, address 0, select a 1 shows the calibration byte.
// - busy goes low within 1 us after the write strobe falls; under the eeprom write command with select a 1 the code stays ready instead.
// - writes hold busy between 3.7 and 4.5 ms after the strobe.
// - chip erase holds busy between 7.5 and 9 ms, then ready.
// - load selects pick address, data, command or nothing on each load strobe.
// - last command and address are kept across operations.
// - eeprom page is 4 bytes; address bits 1:0 pick the byte.
`ifndef PNP_REGS_SVH
`define PNP_REGS_SVH
`define PNP_CMD_NOP      8'h00
`define PNP_CMD_ERASE    8'h80
`define PNP_CMD_WFUSE    8'h40
`define PNP_CMD_WLOCK    8'h20
`define PNP_CMD_WFLASH   8'h10
`define PNP_CMD_WEE      8'h11
`define PNP_CMD_RSIG     8'h08
`define PNP_CMD_RFUSE    8'h04
`define PNP_CMD_RFLASH   8'h02
`define PNP_CMD_REE      8'h03
`define PNP_LD_ADDR      2'h0
`define PNP_LD_DATA      2'h1
`define PNP_LD_CMD       2'h2
`define PNP_CLK_MHZ      200
`define PNP_WLRL_NS      1000
`define PNP_WLRH_US      4
`define PNP_WLRH_CE_US   8
`define PNP_WLRL_CYC     (`PNP_WLRL_NS * `PNP_CLK_MHZ / 1000)
`define PNP_WRITE_CYC    (`PNP_WLRH_US * `PNP_CLK_MHZ * 1000)
`define PNP_ERASE_CYC    (`PNP_WLRH_CE_US * `PNP_CLK_MHZ * 1000)
`define PNP_FUSE_LO_RST  8'hFF
`define PNP_FUSE_HI_RST  8'hFF
`define PNP_FUSE_EX_RST  8'hFF
`define PNP_LOCK_RST     8'hFF
`define PNP_CAL_VAL      8'h80
`endif

// ===== hdl/pnp_pkg.sv
// types of the parallel programming port
// assumes pnp_regs.svh provides the numeric constants
package pnp_pkg;
  typedef enum logic [2:0] {
    PNP_IDLE  = 3'b001,
    PNP_BUSY  = 3'b010,
    PNP_ERASE = 3'b100
  } pnp_state_e;

  // programmer-facing pin group, sampled synchronously
  typedef struct packed {
    logic [7:0] data;
    logic       load_sel_hi;
    logic       load_sel_lo;
    logic       byte_sel_a;
    logic       byte_sel_b;
    logic       buffer_latch;
    logic       load_strobe;
    logic       wr_n;
    logic       oe_n;
  } pnp_pins_s;

  // non-volatile bytes kept by the port
  typedef struct packed {
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ex;
    logic [7:0] lock;
  } pnp_nv_s;
endpackage : pnp_pkg

// ===== hdl/pnp_edge.sv
// rising/falling edge detector for one synchronous strobe
// assumes strobe already synchronous to core_clk_i
`timescale 1ns/10ps
module pnp_edge (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic sig_i,
  input  wire logic rst_val_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_reg;

  // previous level, reset to idle-low
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig_i;
    end
  end

  // edges against the previous sample; rst_val_i high arms the falling edge output
  assign rise_o = sig_i & ~prev_reg;
  assign fall_o = ~sig_i & prev_reg & rst_val_i;
endmodule : pnp_edge

// ===== sim/pnp_prog_model.sv
// programmer model: drives the port's pin group and times every strobe
// assumes pins change on falling clock edges and the bus is resolved outside
`timescale 1ns/10ps
module pnp_prog_model (
  input  wire logic          core_clk_i,
  input  wire logic          done_flag_i,
  input  wire logic [7:0]    bus_i,
  input  wire logic          bus_oe_i,
  output pnp_pkg::pnp_pins_s pins_o
);
  // 30 cycles covers every setup, hold and pulse width minimum
  localparam int PW = 30;

  // idle: selects at no action, strobes low, write and output enable high
  initial begin
    pins_o = 16'h00C3;
  end

  // one load strobe pulse with load selects and byte select a
  task automatic ld(input logic [1:0] sel, input logic a, input logic [7:0] val);
    @(negedge core_clk_i);
    {pins_o.load_sel_hi, pins_o.load_sel_lo} = sel;
    pins_o.byte_sel_a = a;
    pins_o.data = val;
    repeat (PW) @(negedge core_clk_i);
    pins_o.load_strobe = 1'b1;
    repeat (PW) @(negedge core_clk_i);
    pins_o.load_strobe = 1'b0;
    repeat (PW) @(negedge core_clk_i);
    pins_o.data = ~val;  // stale data never looks valid
    pins_o.load_sel_hi = 1'b1;
    pins_o.load_sel_lo = 1'b1;
  endtask : ld

  // page latch pulse
  task automatic latch();
    repeat (PW) @(negedge core_clk_i);
    pins_o.buffer_latch = 1'b1;
    repeat (PW) @(negedge core_clk_i);
    pins_o.buffer_latch = 1'b0;
  endtask : latch

  // write pulse, optional second pulse while busy; counts cycles to ready
  task automatic wr(input logic a, input logic b, input bit extra, output int n, output logic early);
    @(negedge core_clk_i);
    pins_o.byte_sel_a = a;
    pins_o.byte_sel_b = b;
    repeat (PW) @(negedge core_clk_i);
    pins_o.wr_n = 1'b0;
    repeat (PW) @(negedge core_clk_i);
    early = done_flag_i;
    pins_o.wr_n = 1'b1;
    n = PW;
    if (extra) begin
      repeat (PW) @(negedge core_clk_i);
      pins_o.wr_n = 1'b0;
      repeat (PW) @(negedge core_clk_i);
      pins_o.wr_n = 1'b1;
      n = 3 * PW;
    end
    while (done_flag_i !== 1'b1 && n < 100000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask : wr

  // read with output enable low and byte selects (b, a)
  task automatic rd(input logic b, input logic a, output logic [7:0] v, output logic oe);
    @(negedge core_clk_i);
    pins_o.byte_sel_b = b;
    pins_o.byte_sel_a = a;
    pins_o.oe_n = 1'b0;
    repeat (PW) @(negedge core_clk_i);
    v = bus_i;
    oe = bus_oe_i;
    pins_o.oe_n = 1'b1;
    repeat (PW) @(negedge core_clk_i);
  endtask : rd
endmodule : pnp_prog_model

// ===== sim/parallel_nvm_program_port_test.sv
// testbench of the programming port: programmer model, flash stand-in, checks
// assumes write counts shortened to 100 and 200 cycles
`timescale 1ns/10ps
`include "pnp_regs.svh"
module parallel_nvm_program_port_test;
  localparam int WCYC = 100;
  localparam int ECYC = 200;
  logic               core_clk_i = 1'b0;
  logic               rstn_i     = 1'b0;
  pnp_pkg::pnp_pins_s pins;
  logic [7:0]         dout, bus, flo, fhi, fex, lck, v;
  logic [15:0]        faddr;
  logic               oe, done, fwr, fer, o;
  int                 fail_count      = 0;
  int                 samples_checked = 0;
  logic [7:0]         lk_in[4]  = '{8'hF3, 8'hFF, 8'hF0, 8'hE0};
  logic [7:0]         lk_exp[4] = '{8'hF3, 8'hF3, 8'hF0, 8'hF0};
  logic [7:0]         sig[3]    = '{8'h3A, 8'h55, 8'hAA};  // arbitrary values
  logic [1:0]         seen      = 2'b00;  // flash write / erase strobes seen high
  int                 wn;
  logic               we;

  // clock and bus resolution
  always #2.5 core_clk_i = ~core_clk_i;
  assign bus = oe ? dout : pins.data;

  // remember whether the flash write and erase outputs were ever raised
  always @(negedge core_clk_i) begin
    seen <= seen | {fwr, fer};
  end

  pnp_prog_model prog (.core_clk_i(core_clk_i), .done_flag_i(done), .bus_i(bus), .bus_oe_i(oe), .pins_o(pins));

  pnp_port #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .data_i(bus), .data_o(dout), .data_oe_o(oe),
    .load_sel_hi_i(pins.load_sel_hi), .load_sel_lo_i(pins.load_sel_lo), .byte_sel_a_i(pins.byte_sel_a),
    .byte_sel_b_i(pins.byte_sel_b), .buffer_latch_i(pins.buffer_latch), .load_strobe_i(pins.load_strobe),
    .wr_n_i(pins.wr_n), .oe_n_i(pins.oe_n), .done_flag_o(done), .flash_word_i(~faddr),
    .flash_addr_o(faddr), .flash_write_o(fwr), .flash_erase_o(fer), .fuse_lo_o(flo),
    .fuse_hi_o(fhi), .fuse_ex_o(fex), .lock_o(lck));

  // compare a byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // compare a cycle count against a window
  task automatic chkn(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("unexpected at %0t: busy for %0d cycles", $time, n);
    end
  endtask : chkn

  // verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // write pulse with busy checks
  task automatic do_write(input logic a, input logic b, input bit extra, input int cyc);
    int   n;
    logic early;
    prog.wr(a, b, extra, n, early);
    chk8({7'h00, early}, 8'h00);
    chkn(n, cyc, cyc + 3);
  endtask : do_write

  // read and check data, then check the bus is released
  task automatic rdchk(input logic b, input logic a, input logic [7:0] exp);
    prog.rd(b, a, v, o);
    chk8(v, exp);
    chk8({7'h00, o, oe}, 8'h02);
  endtask : rdchk

  // main sequence
  initial begin : main
    repeat (10) @(negedge core_clk_i);
    rstn_i = 1'b1;
    chk8({done, 7'h00} | (flo & fhi & fex & lck & 8'h7F), 8'hFF);
    prog.ld(2'b10, 1'b0, 8'h40);
    prog.ld(2'b01, 1'b0, 8'hA5);
    do_write(1'b0, 1'b0, 1'b0, WCYC);
    chk8(flo, 8'hA5);
    prog.ld(2'b01, 1'b0, 8'h5A);
    do_write(1'b1, 1'b0, 1'b1, WCYC);
    chk8(fhi, 8'h5A);
    prog.ld(2'b01, 1'b0, 8'h3C);
    do_write(1'b0, 1'b1, 1'b0, WCYC);
    chk8(fex, 8'h3C);
    prog.ld(2'b10, 1'b0, 8'h20);
    for (int i = 0; i < 4; i++) begin
      prog.ld(2'b01, 1'b0, lk_in[i]);
      do_write(1'b0, 1'b0, 1'b0, WCYC);
      chk8(lck, lk_exp[i]);
    end
    prog.ld(2'b10, 1'b0, 8'h04);
    rdchk(1'b0, 1'b0, 8'hA5);
    rdchk(1'b1, 1'b1, 8'h5A);
    rdchk(1'b1, 1'b0, 8'h3C);
    rdchk(1'b0, 1'b1, 8'hF0);
    prog.ld(2'b10, 1'b0, 8'h11);
    prog.ld(2'b00, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      prog.ld(2'b00, 1'b0, 8'h04 + 8'(i));
      prog.ld(2'b01, 1'b0, 8'hC0 + 8'(i));
      prog.latch();
    end
    prog.wr(1'b1, 1'b0, 1'b0, wn, we);
    chk8({7'h00, we}, 8'h01);
    chkn(wn, 30, 30);
    do_write(1'b0, 1'b0, 1'b0, WCYC);
    prog.ld(2'b10, 1'b0, 8'h10);
    do_write(1'b0, 1'b0, 1'b0, WCYC);
    chk8({6'h00, seen}, 8'h02);
    prog.ld(2'b10, 1'b0, 8'h00);
    chk8({fwr, done}, 8'h01);
    prog.ld(2'b10, 1'b0, 8'h03);
    for (int i = 0; i < 4; i++) begin
      prog.ld(2'b00, 1'b0, 8'h04 + 8'(i));
      rdchk(1'b0, 1'b0, 8'hC0 + 8'(i));
    end
    prog.ld(2'b10, 1'b0, 8'h11);
    prog.ld(2'b00, 1'b0, 8'h04);
    prog.ld(2'b01, 1'b0, 8'h77);
    prog.latch();
    prog.ld(2'b10, 1'b0, 8'h00);
    prog.ld(2'b10, 1'b0, 8'h11);
    do_write(1'b0, 1'b0, 1'b0, WCYC);
    prog.ld(2'b10, 1'b0, 8'h03);
    rdchk(1'b0, 1'b0, 8'hC0);
    prog.ld(2'b10, 1'b0, 8'h02);
    prog.ld(2'b00, 1'b1, 8'h12);
    prog.ld(2'b00, 1'b0, 8'h34);
    chk8(faddr[15:8], 8'h12);
    rdchk(1'b0, 1'b0, 8'hCB);
    rdchk(1'b0, 1'b1, 8'hED);
    prog.ld(2'b10, 1'b0, 8'h08);
    for (int i = 0; i < 3; i++) begin
      prog.ld(2'b00, 1'b0, 8'(i));
      rdchk(1'b0, 1'b0, sig[i]);
    end
    prog.ld(2'b00, 1'b0, 8'h00);
    rdchk(1'b0, 1'b1, `PNP_CAL_VAL);
    prog.ld(2'b10, 1'b0, 8'h80);
    do_write(1'b0, 1'b0, 1'b0, ECYC);
    chk8(lck, 8'hFF);
    chk8({6'h00, seen}, 8'h03);
    chk8(flo, 8'hA5);
    stop_test();
  end

  // watchdog well beyond the expected run
  initial begin : watchdog
    #150000;
    fail_count++;
    stop_test();
  end
endmodule : parallel_nvm_program_port_test
